// *** logic/fault_limit_pkg.sv ***
/*
 * Constants for the output fault and current limit block: command
 * offsets, register reset words, field positions and retry timing.
 * Assumes a single 20 MHz core clock.
 */
package fault_limit_pkg;

    // command offsets of the three limit and response registers
    localparam logic [7:0]  UV_RESPONSE_OFFSET   = 8'h45;
    localparam logic [7:0]  OC_LIMIT_OFFSET      = 8'h46;
    localparam logic [7:0]  UC_LIMIT_OFFSET      = 8'h4B;

    // reset words
    localparam logic [7:0]  UV_RESPONSE_RESET    = 8'h80;
    localparam logic [15:0] OC_LIMIT_RESET       = 16'hDBC0;
    localparam logic [15:0] UC_LIMIT_RESET       = 16'hD440;

    // response byte fields
    localparam int          BEHAV_MSB            = 7;
    localparam int          BEHAV_LSB            = 6;
    localparam int          RETRY_MSB            = 5;
    localparam int          RETRY_LSB            = 3;
    localparam logic [1:0]  BEHAV_DISABLE_RETRY  = 2'h2;
    localparam logic [2:0]  RETRY_NONE           = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER        = 3'h7;

    // limit word fields: signed exponent over signed mantissa
    localparam int          EXP_MSB              = 15;
    localparam int          EXP_LSB              = 11;
    localparam int          MANT_MSB             = 10;
    localparam int          MANT_LSB             = 0;

    // current samples carry this many fraction bits (amps x 16)
    localparam int          CUR_FRAC_BITS        = 4;
    localparam int          CUR_WIDTH            = 16;
    localparam int          LIM_WIDTH            = 32;

    // retry spacing
    localparam int          CLK_HZ               = 20000000;
    localparam int          RETRY_TIME_MS        = 70;
    localparam int          RETRY_CYCLES         = RETRY_TIME_MS * (CLK_HZ / 1000);
    localparam int          RETRY_CNT_WIDTH      = 21;

    // run length field width of the current sense setup
    localparam int          RUN_WIDTH            = 4;

    typedef enum logic [1:0] {
        OUT_OFF,
        OUT_ON,
        OUT_FAULT_HOLD,
        OUT_RETRY_WAIT
    } out_state_t;

endpackage

// *** logic/linear_limit_decode.sv ***
/*
 * Decodes one exponent/mantissa limit word into a signed fixed point
 * value with the sample fraction width. Purely combinational.
 * Assumes the caller registers or compares the result in its own clock.
 */
`timescale 1ns/1ps
`default_nettype none

module linear_limit_decode
    import fault_limit_pkg::*;
(
    input  wire logic [15:0]                  limitWord,   // raw register word
    output logic signed [fault_limit_pkg::LIM_WIDTH-1:0] limitValue // limit, amps x 16
);

    logic signed [4:0]           expField;
    logic signed [10:0]          mantField;
    logic signed [5:0]           shiftAmt;
    logic signed [LIM_WIDTH-1:0] mantWide;
    logic [4:0]                  leftShift;
    logic [4:0]                  rightShift;

    // R16 split fields
    assign expField   = limitWord[EXP_MSB:EXP_LSB];
    assign mantField  = limitWord[MANT_MSB:MANT_LSB];
    assign mantWide   = LIM_WIDTH'(mantField);

    // scale to sample units; exponent range -16..15 keeps shift within 32 bits
    assign shiftAmt   = 6'(expField) + 6'(CUR_FRAC_BITS);
    assign leftShift  = shiftAmt[5] ? 5'h00 : shiftAmt[4:0];
    assign rightShift = shiftAmt[5] ? 5'((~shiftAmt) + 6'h01) : 5'h00;

    // R15 value is mantissa times two to the exponent
    assign limitValue = shiftAmt[5] ? (mantWide >>> rightShift) : (mantWide <<< leftShift);

endmodule

`default_nettype wire

// *** logic/output_fault_limit_response.sv ***
/*
 * Output undervoltage response and per-phase peak/valley current limits.
 * Registers are reached through a decoded command port (code, data,
 * write and read strobes) from the bus front end, which is outside.
 * Pins powerGood, uvBelow, enablePin and biasOk are asynchronous and
 * are synchronised here; all other inputs share clk.
 */
// Contract
// R1: undervoltage detected only after power-good asserted
// R2: behaviour 10 disables output, then retries; the code retries only with retry 111, and codes 001 to 110 latch off
// R3: fault drives alert line low
// R4: fault bits cleared only by clear-faults
// R5: retry 000 keeps output off until cleared
// R6: retry 111 restarts until off, bias, fault
// R7: low bits ignored, fixed 70ms retry spacing
// R8: response byte resets to 80h
// R9: either phase peak exceeds overcurrent limit
// R10: compare only samples after blanking time
// R11: fault after consecutive run of periods
// R12: peak overcurrent shares average overcurrent status
// R13: either phase valley below undercurrent limit
// R14: valley undercurrent shares average undercurrent status
// R15: limits are exponent/mantissa 16-bit words
// R16: exponent bits 15:11, mantissa bits 10:0
// R17: limits reset to 30A and -15A
`timescale 1ns/1ps
`default_nettype none

module output_fault_limit_response
    import fault_limit_pkg::*;
#(
    parameter int RETRY_WAIT_CYCLES = fault_limit_pkg::RETRY_CYCLES
)
(
    input  wire logic                    clk,            // core clock, 20 MHz
    input  wire logic                    rst,            // async reset, active high
    // command port
    input  wire logic                    cmdWrite,       // write strobe, one cycle
    input  wire logic                    cmdRead,        // read strobe, one cycle
    input  wire logic [7:0]              cmdCode,        // command offset
    input  wire logic [15:0]             cmdWdata,       // write data
    input  wire logic                    clearFaults,    // clear-faults command pulse
    output logic [15:0]                  readData,       // read data, registered
    output logic                         readValid,      // read answer pulse
    // pins
    input  wire logic                    powerGood,      // power-good flag pin
    input  wire logic                    uvBelow,        // output below uv limit
    input  wire logic                    enablePin,      // enable pin level
    input  wire logic                    biasOk,         // bias supply present
    // same-domain controls
    input  wire logic                    operationOn,    // operation command on
    input  wire logic                    otherShutdown,  // another fault forces off
    input  wire logic [fault_limit_pkg::RUN_WIDTH-1:0] runLength, // sense setup run
    input  wire logic                    sampleValid,    // one sample per period
    input  wire logic                    blankExpired,   // blanking time over
    input  wire logic signed [15:0]      phase0Current,  // phase 0 amps x 16
    input  wire logic signed [15:0]      phase1Current,  // phase 1 amps x 16
    input  wire logic                    avgOcViolation, // average oc fault pulse
    input  wire logic                    avgUcViolation, // average uc fault pulse
    // outputs
    output logic                         outputEnable,   // power stage enable
    output logic                         uvFault,        // uv status bit
    output logic                         ocFault,        // oc status bit
    output logic                         ucFault,        // uc status bit
    output logic                         hostAlertN      // alert line, active low
);

    localparam logic [RETRY_CNT_WIDTH-1:0] RETRY_LAST =
        RETRY_CNT_WIDTH'(RETRY_WAIT_CYCLES - 1);

    // registers
    logic [7:0]                  uvResponse_r;
    logic [15:0]                 ocLimit_r;
    logic [15:0]                 ucLimit_r;
    logic [15:0]                 readData_r;
    logic                        readValid_r;
    logic [3:0]                  syncA_r;
    logic [3:0]                  syncB_r;
    out_state_t                  state_r;
    out_state_t                  state_nxt;
    logic [RETRY_CNT_WIDTH-1:0]  retryCnt_r;
    logic [RETRY_CNT_WIDTH-1:0]  retryCnt_nxt;
    logic [RUN_WIDTH-1:0]        ocRun_r;
    logic [RUN_WIDTH-1:0]        ucRun_r;
    logic                        uvFault_r;
    logic                        ocFault_r;
    logic                        ucFault_r;
    logic                        outputEnable_r;
    logic                        hostAlertN_r;

    // decoded values and conditions
    logic signed [LIM_WIDTH-1:0] ocLimitValue;
    logic signed [LIM_WIDTH-1:0] ucLimitValue;
    logic [1:0]                  phaseOver;
    logic [1:0]                  phaseUnder;
    logic                        anyOver;
    logic                        anyUnder;
    logic                        validSample;
    logic                        ocRunDone;
    logic                        ucRunDone;
    logic                        ocSet;
    logic                        ucSet;
    logic                        pgSync;
    logic                        uvSync;
    logic                        enSync;
    logic                        biasSync;
    logic                        runRequest;
    logic                        uvDetect;
    logic [1:0]                  behavField;
    logic [2:0]                  retryField;
    logic                        retryForever;
    logic                        selUv;
    logic                        selOc;
    logic                        selUc;
    logic [15:0]                 readMux;
    logic                        retryExpired;

    // pins pass two flops before anything reads them
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            syncA_r <= 4'h0;
            syncB_r <= 4'h0;
        end
        else
        begin
            syncA_r <= {biasOk, enablePin, uvBelow, powerGood};
            syncB_r <= syncA_r;
        end
    end

    assign pgSync   = syncB_r[0];
    assign uvSync   = syncB_r[1];
    assign enSync   = syncB_r[2];
    assign biasSync = syncB_r[3];

    // command decode
    assign selUv = (cmdCode == UV_RESPONSE_OFFSET);
    assign selOc = (cmdCode == OC_LIMIT_OFFSET);
    assign selUc = (cmdCode == UC_LIMIT_OFFSET);

    // unmapped codes read as zero
    assign readMux = selUv ? {8'h00, uvResponse_r} :
                     selOc ? ocLimit_r :
                     selUc ? ucLimit_r : 16'h0000;

    // R8 response byte resets to 80h
    // R17 limit words reset to 30 A and -15 A
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            uvResponse_r <= UV_RESPONSE_RESET;
            ocLimit_r    <= OC_LIMIT_RESET;
            ucLimit_r    <= UC_LIMIT_RESET;
        end
        else if (cmdWrite)
        begin
            if (selUv)
                uvResponse_r <= cmdWdata[7:0];
            if (selOc)
                ocLimit_r <= cmdWdata;
            if (selUc)
                ucLimit_r <= cmdWdata;
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            readData_r  <= 16'h0000;
            readValid_r <= 1'b0;
        end
        else
        begin
            readValid_r <= cmdRead;
            if (cmdRead)
                readData_r <= readMux;
        end
    end

    // R15 both limits decoded from exponent/mantissa words
    linear_limit_decode ocDecode (
        .limitWord  (ocLimit_r),
        .limitValue (ocLimitValue)
    );

    linear_limit_decode ucDecode (
        .limitWord  (ucLimit_r),
        .limitValue (ucLimitValue)
    );

    // per-phase comparison against the common limits
    generate
        for (genvar ph = 0; ph < 2; ph++)
        begin : g_phase
            logic signed [LIM_WIDTH-1:0] curWide;
            assign curWide = (ph == 0) ? LIM_WIDTH'(phase0Current)
                                       : LIM_WIDTH'(phase1Current);
            assign phaseOver[ph]  = (curWide > ocLimitValue);
            assign phaseUnder[ph] = (curWide < ucLimitValue);
        end
    endgenerate

    // R9 either phase alone can raise overcurrent
    assign anyOver  = |phaseOver;
    // R13 either phase alone can raise undercurrent
    assign anyUnder = |phaseUnder;

    // R10 samples inside blanking are not compared
    assign validSample = sampleValid & blankExpired;

    // a zero run length still needs one violating period
    assign ocRunDone = anyOver  & ((ocRun_r + 1'b1) >= runLength);
    assign ucRunDone = anyUnder & ((ucRun_r + 1'b1) >= runLength);

    // R11 count consecutive violating periods, reset on a clean one
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ocRun_r <= '0;
            ucRun_r <= '0;
        end
        else if (validSample)
        begin
            ocRun_r <= (anyOver  && !ocRunDone) ? ocRun_r + 1'b1 : '0;
            ucRun_r <= (anyUnder && !ucRunDone) ? ucRun_r + 1'b1 : '0;
        end
    end

    // R12 peak and average overcurrent share one status bit
    assign ocSet = (validSample & ocRunDone) | avgOcViolation;
    // R14 valley and average undercurrent share one status bit
    assign ucSet = (validSample & ucRunDone) | avgUcViolation;

    // R1 undervoltage only counts once power-good is up and running
    assign uvDetect = pgSync & uvSync & (state_r == OUT_ON);

    // R4 sticky bits, set beats a same-cycle clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            uvFault_r <= 1'b0;
            ocFault_r <= 1'b0;
            ucFault_r <= 1'b0;
        end
        else
        begin
            uvFault_r <= uvDetect | (uvFault_r & ~clearFaults);
            ocFault_r <= ocSet    | (ocFault_r & ~clearFaults);
            ucFault_r <= ucSet    | (ucFault_r & ~clearFaults);
        end
    end

    // R3 alert low while any fault stands or is being raised
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hostAlertN_r <= 1'b1;
        else
            hostAlertN_r <= ~(uvFault_r | ocFault_r | ucFault_r | uvDetect | ocSet | ucSet);
    end

    // R7 bits 2:0 are never looked at
    assign behavField   = uvResponse_r[BEHAV_MSB:BEHAV_LSB];
    assign retryField   = uvResponse_r[RETRY_MSB:RETRY_LSB];
    assign retryForever = (behavField == BEHAV_DISABLE_RETRY) && (retryField == RETRY_FOREVER);

    // commanded on, biased and not shut by another fault
    assign runRequest   = enSync & operationOn & biasSync & ~otherShutdown;
    assign retryExpired = (retryCnt_r == RETRY_LAST);

    // output state: unused behaviour and retry codes fall back to latch-off
    always_comb
    begin
        state_nxt    = state_r;
        retryCnt_nxt = retryCnt_r;
        case (state_r)
            OUT_OFF:
            begin
                if (runRequest)
                    state_nxt = OUT_ON;
            end
            OUT_ON:
            begin
                if (!runRequest)
                    state_nxt = OUT_OFF;
                // R2 disable on fault, then retry per field
                else if (uvDetect && retryForever)
                begin
                    state_nxt    = OUT_RETRY_WAIT;
                    retryCnt_nxt = '0;
                end
                // R5 no retry, stay off until cleared
                else if (uvDetect)
                    state_nxt = OUT_FAULT_HOLD;
            end
            OUT_FAULT_HOLD:
            begin
                if (clearFaults)
                    state_nxt = OUT_OFF;
            end
            OUT_RETRY_WAIT:
            begin
                // R6 a command off, lost bias or other fault ends retrying
                if (!runRequest)
                    state_nxt = OUT_OFF;
                // R7 fixed spacing between restart attempts
                else if (retryExpired)
                    state_nxt = OUT_ON;
                else
                    retryCnt_nxt = retryCnt_r + 1'b1;
            end
            default:
                state_nxt = OUT_OFF;
        endcase
    end

    // state and retry timer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r    <= OUT_OFF;
            retryCnt_r <= '0;
        end
        else
        begin
            state_r    <= state_nxt;
            retryCnt_r <= retryCnt_nxt;
        end
    end

    // enable follows the next state so the stage drops in the fault cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            outputEnable_r <= 1'b0;
        else
            outputEnable_r <= (state_nxt == OUT_ON);
    end

    // outputs straight from flops
    assign readData     = readData_r;
    assign readValid    = readValid_r;
    assign outputEnable = outputEnable_r;
    assign uvFault      = uvFault_r;
    assign ocFault      = ocFault_r;
    assign ucFault      = ucFault_r;
    assign hostAlertN   = hostAlertN_r;

endmodule

`default_nettype wire

// *** sim/output_fault_limit_response_props.sv ***
/*
 * Port checker for the output fault and current limit block.
 * Assumes a bind onto that block and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module output_fault_limit_response_props
    import fault_limit_pkg::*;
#(
    parameter int RETRY_WAIT_CYCLES = 20
)
(
    input wire logic        clk,            // core clock
    input wire logic        rst,            // async reset
    input wire logic        cmdWrite,       // write strobe
    input wire logic        cmdRead,        // read strobe
    input wire logic [7:0]  cmdCode,        // command offset
    input wire logic [15:0] cmdWdata,       // write data
    input wire logic        clearFaults,    // clear pulse
    input wire logic [15:0] readData,       // read data
    input wire logic        readValid,      // read answer
    input wire logic        powerGood,      // power-good pin
    input wire logic        uvBelow,        // output low pin
    input wire logic        enablePin,      // enable pin
    input wire logic        biasOk,         // bias present
    input wire logic        operationOn,    // operation on
    input wire logic        otherShutdown,  // other fault
    input wire logic        sampleValid,    // sample strobe
    input wire logic        blankExpired,   // blanking over
    input wire logic        avgOcViolation, // average oc
    input wire logic        avgUcViolation, // average uc
    input wire logic        outputEnable,   // stage enable
    input wire logic        uvFault,        // uv status
    input wire logic        ocFault,        // oc status
    input wire logic        ucFault,        // uc status
    input wire logic        hostAlertN      // alert, low
);
    logic [7:0] respByte_r;
    logic [7:0] offCnt_r;
    wire        runOn = enablePin && operationOn && biasOk && !otherShutdown;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // mirror of the response byte; the upper write byte is dropped
    always_ff @(posedge clk or posedge rst)
        if (rst) respByte_r <= 8'h80;
        else if (cmdWrite && cmdCode == 8'h45) respByte_r <= cmdWdata[7:0];

    // off-stretch length, saturating so it never wraps
    always_ff @(posedge clk or posedge rst)
        if (rst) offCnt_r <= 8'h00;
        else if (outputEnable) offCnt_r <= 8'h00;
        else if (offCnt_r != 8'hFF) offCnt_r <= offCnt_r + 8'h01;

    uv_needs_pg_a: assert property ($rose(uvFault) |->
        $past(powerGood, 3) && $past(uvBelow, 3))
        else $error("uv fault without power good");
    uv_disables_a: assert property ($rose(uvFault) |-> !outputEnable)
        else $error("output on at uv fault");
    alert_on_fault_a: assert property ((uvFault || ocFault || ucFault) |-> !hostAlertN)
        else $error("alert high with fault");
    fault_sticky_a: assert property
        (($fell(uvFault) || $fell(ocFault) || $fell(ucFault)) |-> $past(clearFaults))
        else $error("fault cleared unasked");
    no_retry_a: assert property (uvFault && respByte_r[5:3] == 3'h0 |-> !outputEnable)
        else $error("restart with retry off");
    retry_bound_a: assert property
        (uvFault && respByte_r[7:3] == 5'h17 && runOn |-> offCnt_r <= RETRY_WAIT_CYCLES + 6)
        else $error("retry too late");
    retry_gap_a: assert property
        ($rose(outputEnable) && uvFault |-> offCnt_r >= RETRY_WAIT_CYCLES - 1)
        else $error("retry too early");
    read_back_a: assert property
        (cmdRead && cmdCode == 8'h45 |=> readValid && readData == {8'h00, respByte_r})
        else $error("response byte read wrong");
    oc_source_a: assert property ($rose(ocFault) |->
        $past(avgOcViolation) || ($past(sampleValid) && $past(blankExpired)))
        else $error("oc fault from blanked sample");
    uc_source_a: assert property ($rose(ucFault) |->
        $past(avgUcViolation) || ($past(sampleValid) && $past(blankExpired)))
        else $error("uc fault from blanked sample");

    oc_seen_c: cover property ($rose(ocFault));
    uc_seen_c: cover property ($rose(ucFault));
    retry_seen_c: cover property ($rose(outputEnable) && uvFault);
endmodule

bind output_fault_limit_response output_fault_limit_response_props
    #(.RETRY_WAIT_CYCLES(RETRY_WAIT_CYCLES))
    output_fault_limit_response_props_i (.clk, .rst, .cmdWrite, .cmdRead, .cmdCode,
    .cmdWdata, .clearFaults, .readData, .readValid, .powerGood, .uvBelow, .enablePin,
    .biasOk, .operationOn, .otherShutdown, .sampleValid, .blankExpired, .avgOcViolation,
    .avgUcViolation, .outputEnable, .uvFault, .ocFault, .ucFault, .hostAlertN);

`default_nettype wire

// *** sim/host_model.sv ***
/*
 * Host side model: drives the decoded command port.
 * Assumes requests start at falling edges and last one rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module host_model
(
    input  wire logic        clk,        // core clock
    input  wire logic [15:0] readData,   // read answer
    input  wire logic        readValid,  // answer strobe
    output logic             cmdWrite = 1'b0,    // write strobe
    output logic             cmdRead = 1'b0,     // read strobe
    output logic [7:0]       cmdCode = 8'h00,    // command offset
    output logic [15:0]      cmdWdata = 16'h0,   // write data
    output logic             clearFaults = 1'b0  // clear pulse
);
    // idle code and data are inverted so nothing leans on stale values
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk);
        cmdWrite = 1'b1;
        cmdCode = c;
        cmdWdata = d;
        @(negedge clk);
        cmdWrite = 1'b0;
        cmdCode = ~c;
        cmdWdata = ~d;
    endtask

    // answer is taken one cycle after the strobe edge
    task automatic rd(input logic [7:0] c, output logic v, output logic [15:0] d);
        @(negedge clk);
        cmdRead = 1'b1;
        cmdCode = c;
        @(negedge clk);
        cmdRead = 1'b0;
        cmdCode = ~c;
        v = readValid;
        d = readData;
    endtask

    // clear-faults pulse, one edge wide
    task automatic clr();
        @(negedge clk);
        clearFaults = 1'b1;
        @(negedge clk);
        clearFaults = 1'b0;
    endtask
endmodule

`default_nettype wire

// *** sim/output_fault_limit_response_test.sv ***
/*
 * Self-checking bench for the output fault and current limit block.
 * Assumes the host model owns the command port; pins change at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module output_fault_limit_response_test;
    import fault_limit_pkg::*;

    localparam int RW = 20;
    logic clk = 1'b0, rst = 1'b1, powerGood = 1'b0, uvBelow = 1'b0;
    logic enablePin = 1'b1, biasOk = 1'b1, operationOn = 1'b1, otherShutdown = 1'b0;
    logic [3:0] runLength = 4'h2;
    logic sampleValid = 1'b0, blankExpired = 1'b0;
    logic avgOcViolation = 1'b0, avgUcViolation = 1'b0;
    logic signed [15:0] phase0Current = 16'sh0000, phase1Current = 16'sh0000;
    logic cmdWrite, cmdRead, clearFaults, readValid;
    logic outputEnable, uvFault, ocFault, ucFault, hostAlertN;
    logic [7:0] cmdCode;
    logic [15:0] cmdWdata, readData;
    int nErrors = 0, compares = 0, cycles = 0, k;

    output_fault_limit_response #(.RETRY_WAIT_CYCLES(RW)) output_fault_limit_response_i (
        .clk, .rst, .cmdWrite, .cmdRead, .cmdCode, .cmdWdata, .clearFaults, .readData,
        .readValid, .powerGood, .uvBelow, .enablePin, .biasOk, .operationOn, .otherShutdown,
        .runLength, .sampleValid, .blankExpired, .phase0Current, .phase1Current,
        .avgOcViolation, .avgUcViolation, .outputEnable, .uvFault, .ocFault, .ucFault,
        .hostAlertN);

    host_model host_model_i (.clk, .readData, .readValid, .cmdWrite, .cmdRead, .cmdCode,
        .cmdWdata, .clearFaults);

    // 20 MHz clock
    always #25 clk = ~clk;

    task automatic finish_test();
        if (nErrors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard, far above the run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            nErrors++;
            finish_test();
        end
    end

    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            nErrors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        chk16({15'h0000, g}, {15'h0000, e});
    endtask

    task automatic rdChk(input logic [7:0] c, input logic [15:0] e);
        logic v;
        logic [15:0] d;
        host_model_i.rd(c, v, d);
        chk1(v, 1'b1);
        chk16(d, e);
    endtask

    // one period sample; currents amps x 16
    task automatic samp(input logic signed [15:0] p0, input logic signed [15:0] p1,
                        input logic b);
        @(negedge clk);
        sampleValid = 1'b1;
        blankExpired = b;
        phase0Current = p0;
        phase1Current = p1;
        @(negedge clk);
        {sampleValid, blankExpired} = 2'h0;
    endtask

    initial
    begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        // defaults; unmapped offset reads zero
        rdChk(8'h45, 16'h0080);
        rdChk(8'h46, 16'hDBC0);
        rdChk(8'h4B, 16'hD440);
        rdChk(8'h44, 16'h0000);
        // 30 A is no violation; blanked samples neither count nor break
        samp(16'sh0000, 16'sh01E0, 1'b1);
        samp(16'sh0000, 16'sh01E0, 1'b1);
        samp(16'sh0000, 16'sh01F0, 1'b1);
        samp(16'sh0000, 16'sh01F0, 1'b0);
        chk1(ocFault, 1'b0);
        samp(16'sh0000, 16'sh01F0, 1'b1);
        chk1(ocFault, 1'b1);
        chk1(hostAlertN, 1'b0);
        host_model_i.clr();
        chk1(ocFault, 1'b0);
        // valley below -15 A on phase 0 only
        samp(16'shFF00, 16'sh0000, 1'b1);
        samp(16'shFF00, 16'sh0000, 1'b1);
        chk1(ucFault, 1'b1);
        chk1(ocFault, 1'b0);
        host_model_i.clr();
        // average limit pulses share status bits
        @(negedge clk);
        {avgOcViolation, avgUcViolation} = 2'h3;
        @(negedge clk);
        {avgOcViolation, avgUcViolation} = 2'h0;
        chk1(ocFault, 1'b1);
        chk1(ucFault, 1'b1);
        host_model_i.clr();
        // 10 A limit, negative exponent, one-period run
        runLength = 4'h1;
        host_model_i.wr(8'h46, 16'hF814);
        rdChk(8'h46, 16'hF814);
        samp(16'sh0000, 16'sh00A8, 1'b1);
        chk1(ocFault, 1'b1);
        host_model_i.clr();
        // undervoltage is masked until power good
        chk1(outputEnable, 1'b1);
        uvBelow = 1'b1;
        repeat (10) @(negedge clk);
        chk1(uvFault, 1'b0);
        powerGood = 1'b1;
        for (k = 0; k < 8 && uvFault !== 1'b1; k++) @(negedge clk);
        chk1(uvFault, 1'b1);
        chk1(outputEnable, 1'b0);
        chk1(hostAlertN, 1'b0);
        repeat (3 * RW) @(negedge clk);
        chk1(outputEnable, 1'b0);
        uvBelow = 1'b0;
        host_model_i.clr();
        for (k = 0; k < 8 && outputEnable !== 1'b1; k++) @(negedge clk);
        chk1(outputEnable, 1'b1);
        // retry forever; low bits, upper byte ignored
        host_model_i.wr(8'h45, 16'hA5BF);
        rdChk(8'h45, 16'h00BF);
        uvBelow = 1'b1;
        for (k = 0; k < 8 && outputEnable !== 1'b0; k++) @(negedge clk);
        uvBelow = 1'b0;
        chk1(outputEnable, 1'b0);
        repeat (RW - 4) @(negedge clk);
        chk1(outputEnable, 1'b0);
        for (k = 0; k < 12 && outputEnable !== 1'b1; k++) @(negedge clk);
        chk1(outputEnable, 1'b1);
        chk1(uvFault, 1'b1);
        // another fault turns the output off before undervoltage can start a retry
        uvBelow = 1'b1;
        otherShutdown = 1'b1;
        repeat (3 * RW) @(negedge clk);
        chk1(outputEnable, 1'b0);
        finish_test();
    end
endmodule

`default_nettype wire
